// ===== core/debug_link_defs.vh
// Register map, field positions, codes and timing constants of the debug link register set.
`ifndef DEBUG_LINK_DEFS_VH
`define DEBUG_LINK_DEFS_VH
`define OFF_REV_STATUS 4'h0
`define OFF_ERR_STATUS 4'h1
`define OFF_PHY_CTRL 4'h2
`define OFF_PHY_CTRL_TWO 4'h3
`define OFF_KEY_STATUS 4'h7
`define OFF_RESET_REQ 4'h8
`define OFF_CLK_SEL 4'h9
`define OFF_SYS_CTRL 4'ha
`define OFF_SYS_STATUS 4'hb
`define OFF_CRC_STATUS 4'hc
// The revision value is arbitrary.
`define IMPL_REVISION 4'h3
`define GUARD_MAX 8'h80
`define SYS_STATUS_RESET 8'h01
`define DIV_RESET 2'h3
`define CTRL_A_MASK 8'hbf
`define CTRL_B_MASK 8'h1c
`define KEY_WR_MASK 8'h20
`define SYS_CTRL_MASK 8'h03
`define CLK_SEL_MASK 8'h03
`define CLK_SEL_RESET 8'h03
`define SYS_CTRL_RESET 8'h01
`define BIT_GAP_EN 7
`define BIT_PARITY_OFF 5
`define BIT_TIMEOUT_OFF 4
`define BIT_RESP_OFF 3
`define BIT_NACK_OFF 4
`define BIT_CONT_OFF 3
`define BIT_LINK_DIS 2
`define BIT_UROW_KEY 5
`define BIT_PROG_KEY 4
`define BIT_ERASE_KEY 3
`define BIT_UROW_DONE 1
`define SIG_NONE 3'h0
`define SIG_PARITY 3'h1
`define SIG_FRAME 3'h2
`define SIG_TIMEOUT 3'h3
`define SIG_CLOCK 3'h4
`define SIG_BUS 3'h6
`define SIG_CONTENTION 3'h7
`define RESET_HOLD 8'h59
`define RESET_RUN 8'h00
`define GUARD_RESERVED 3'h7
`define TIMEOUT_CYCLES 17'h10000
`define GAP_BITS 2'h2
`endif

// ===== core/link_counter.v
// Down counter used for guard time and inter-byte gap timing.
`timescale 1ns/1ps
module link_counter
(
  // Clock and reset.
  input wire clk,
  input wire rst_n,
  // Control.
  input wire load,
  input wire [7:0] value,
  // Status.
  output reg busy
);
  reg [7:0] cnt_r;

  // Load wins over the running count so a new request restarts the wait.
  // Busy falls one cycle early because the user registers it, so the registered wait lasts the loaded count.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_r <= 8'h00;
      busy <= 1'b0;
    end
    else if (load)
    begin
      cnt_r <= value;
      busy <= (value > 8'h01);
    end
    else if (cnt_r != 8'h00)
    begin
      cnt_r <= cnt_r - 8'h01;
      busy <= (cnt_r > 8'h02);
    end
  end
endmodule

// ===== core/debug_link_control_regs.v
// Register set and physical-layer control of the single-wire debug link.
//
// Functional notes
// - Registers reachable only through link instructions, no processor bus port exists.
// - Status register one shows read-only implementation revision in bits 7:4.
// - Error signature loads on link error, clears when the debugger reads it.
// - Codes: 1 parity, 2 frame, 3 timeout, 4 clock, 6 bus, 7 contention.
// - Gap enable inserts two idle bit times between multibyte load bytes.
// - Parity off ignores received parity and raises no parity errors.
// - Timeout flagged after 65536 link cycles without access response unless disabled.
// - Response signature off suppresses every response signature.
// - Guard time on receive-to-transmit: 128 cycles halving to 2; code 7 reserved.
// - Negative acknowledge off suppresses the reset-interrupt NACK.
// - Contention detected only while contention detect off is zero.
// - Link disable drops clock request, resets link, clears configuration and keys.
// - User row key flag set on decode; debugger write closes the session.
// - Programming key flag set on decode, cleared while programming start is high.
// - Chip erase key flag set on decode, cleared by erase reset request.
// - Reset signature written to reset request asserts system reset; resets to zero.
// - Value 0x59 holds reset, 0x00 releases; link logic stays out of it.
// - Two-bit divider select picks 32, 16, 8 or 4 MHz; 4 MHz default.
`timescale 1ns/1ps
`include "debug_link_defs.vh"
module debug_link_control_regs
(
  // Clock and asynchronous active-low reset.
  input wire clk,
  input wire nrst,
  // Register access from the link instruction decoder.
  input wire reg_wr,
  input wire reg_rd,
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  // Link error events from the physical layer, one-cycle pulses.
  input wire parity_err,
  input wire frame_err,
  input wire clock_err,
  input wire bus_err,
  input wire contention_seen,
  // Access layer handshake for the timeout.
  input wire acc_request,
  input wire acc_response,
  // Transmit timing requests.
  input wire rx_to_tx,
  input wire tx_byte_done,
  input wire multibyte_load,
  // Response signature requests.
  input wire resp_sig_req,
  input wire nack_req,
  // Key decoder events.
  input wire user_row_key_dec,
  input wire mem_program_key_dec,
  input wire chip_erase_key_dec,
  // System status inputs from pins or other domain.
  input wire program_start_pin,
  input wire [7:0] sys_status_pin,
  input wire [2:0] crc_status_pin,
  // Outputs.
  output reg tx_hold,
  output reg resp_sig_en,
  output reg nack_en,
  output reg parity_check_en,
  output reg contention_check_en,
  output reg phy_enable,
  output reg sys_clock_request,
  output reg system_reset,
  output reg user_row_done,
  output reg [1:0] link_clock_divider
);
  reg [1:0] rst_sync_r;
  wire rst_n;
  reg [7:0] ctrl_a_r;
  reg [7:0] ctrl_b_r;
  reg [2:0] error_signature_r;
  reg [2:0] err_nxt;
  reg user_row_key_flag_r;
  reg mem_program_key_flag_r;
  reg chip_erase_key_flag_r;
  reg [7:0] reset_req_r;
  reg [7:0] clk_sel_r;
  reg [7:0] sys_ctrl_r;
  reg [16:0] timeout_cnt_r;
  reg [2:0] ps_s1_r, ps_s2_r, ps_s3_r;
  reg [7:0] st_s1_r, st_s2_r, st_s3_r;
  reg [2:0] crc_s1_r, crc_s2_r, crc_s3_r;
  reg prog_start_r;
  reg [7:0] sys_status_r;
  reg [2:0] crc_status_r;
  reg [7:0] rdata_nxt;
  reg cnt_load;
  reg [7:0] cnt_value;
  wire cnt_busy;
  wire timeout_hit;
  wire wr_reset_req;
  wire link_dis;

  // Guard time decode: 128 >> code; reserved code falls back to the longest wait.
  function [7:0] guard_cycles;
    input [2:0] sel;
    begin
      if (sel == `GUARD_RESERVED)
        guard_cycles = `GUARD_MAX;
      else
        guard_cycles = `GUARD_MAX >> sel;
    end
  endfunction

  // Reset release through two flops so deassertion is clean.
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rst_sync_r <= 2'b00;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_n = rst_sync_r[1];

  assign link_dis = ctrl_b_r[`BIT_LINK_DIS];
  assign wr_reset_req = reg_wr && (reg_addr == `OFF_RESET_REQ);
  assign timeout_hit = (timeout_cnt_r == `TIMEOUT_CYCLES - 17'h1) && !ctrl_a_r[`BIT_TIMEOUT_OFF];

  // Outside inputs pass three flops; a change is taken once stages two and three agree.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ps_s1_r <= 3'h0; ps_s2_r <= 3'h0; ps_s3_r <= 3'h0;
      st_s1_r <= 8'h00; st_s2_r <= 8'h00; st_s3_r <= 8'h00;
      crc_s1_r <= 3'h0; crc_s2_r <= 3'h0; crc_s3_r <= 3'h0;
      prog_start_r <= 1'b0;
      sys_status_r <= `SYS_STATUS_RESET;
      crc_status_r <= 3'h0;
    end
    else
    begin
      ps_s1_r <= {2'b00, program_start_pin};
      ps_s2_r <= ps_s1_r;
      ps_s3_r <= ps_s2_r;
      st_s1_r <= sys_status_pin;
      st_s2_r <= st_s1_r;
      st_s3_r <= st_s2_r;
      crc_s1_r <= crc_status_pin;
      crc_s2_r <= crc_s1_r;
      crc_s3_r <= crc_s2_r;
      if (ps_s2_r[0] == ps_s3_r[0])
        prog_start_r <= ps_s3_r[0];
      if (st_s2_r == st_s3_r)
        sys_status_r <= st_s3_r;
      if (crc_s2_r == crc_s3_r)
        crc_status_r <= crc_s3_r;
    end
  end

  // Error priority: a new event overrides the read clear so nothing is lost.
  always @*
  begin
    err_nxt = error_signature_r;
    if (reg_rd && (reg_addr == `OFF_ERR_STATUS))
      err_nxt = `SIG_NONE;
    if (contention_seen && !ctrl_b_r[`BIT_CONT_OFF])
      err_nxt = `SIG_CONTENTION;
    else if (bus_err)
      err_nxt = `SIG_BUS;
    else if (clock_err)
      err_nxt = `SIG_CLOCK;
    else if (timeout_hit)
      err_nxt = `SIG_TIMEOUT;
    else if (frame_err)
      err_nxt = `SIG_FRAME;
    else if (parity_err && !ctrl_a_r[`BIT_PARITY_OFF])
      err_nxt = `SIG_PARITY;
  end

  // Configuration and key registers; link disable clears all, itself included, except the reset request and clock select, which reloads 0x03.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_a_r <= 8'h00;
      ctrl_b_r <= 8'h00;
      error_signature_r <= `SIG_NONE;
      user_row_key_flag_r <= 1'b0;
      mem_program_key_flag_r <= 1'b0;
      chip_erase_key_flag_r <= 1'b0;
      reset_req_r <= `RESET_RUN;
      clk_sel_r <= `CLK_SEL_RESET;
      sys_ctrl_r <= `SYS_CTRL_RESET;
    end
    else if (link_dis)
    begin
      // Disable acts as a link reset; the bit itself drops so the link can be re-enabled.
      ctrl_a_r <= 8'h00;
      ctrl_b_r <= 8'h00;
      error_signature_r <= `SIG_NONE;
      user_row_key_flag_r <= 1'b0;
      mem_program_key_flag_r <= 1'b0;
      chip_erase_key_flag_r <= 1'b0;
      clk_sel_r <= `CLK_SEL_RESET;
      sys_ctrl_r <= 8'h00;
    end
    else
    begin
      error_signature_r <= err_nxt;
      if (reg_wr && reg_addr == `OFF_PHY_CTRL)
        ctrl_a_r <= reg_wdata & `CTRL_A_MASK;
      if (reg_wr && reg_addr == `OFF_PHY_CTRL_TWO)
        ctrl_b_r <= reg_wdata & `CTRL_B_MASK;
      if (reg_wr && reg_addr == `OFF_CLK_SEL)
        clk_sel_r <= reg_wdata & `CLK_SEL_MASK;
      if (reg_wr && reg_addr == `OFF_SYS_CTRL)
        sys_ctrl_r <= reg_wdata & `SYS_CTRL_MASK & {6'h3f, user_row_key_flag_r, 1'b1};
      if (wr_reset_req)
        reset_req_r <= reg_wdata;
      // Decode sets win over clears in the same cycle.
      if (user_row_key_dec)
        user_row_key_flag_r <= 1'b1;
      else if (reg_wr && reg_addr == `OFF_KEY_STATUS && reg_wdata[`BIT_UROW_KEY])
        user_row_key_flag_r <= 1'b0;
      if (mem_program_key_dec)
        mem_program_key_flag_r <= 1'b1;
      else if (prog_start_r)
        mem_program_key_flag_r <= 1'b0;
      if (chip_erase_key_dec)
        chip_erase_key_flag_r <= 1'b1;
      else if (wr_reset_req && reg_wdata == `RESET_HOLD)
        chip_erase_key_flag_r <= 1'b0;
    end
  end

  // Access-layer timeout counter, runs only while a request waits.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      timeout_cnt_r <= 17'h0;
    else if (!acc_request || acc_response || timeout_hit || link_dis)
      timeout_cnt_r <= 17'h0;
    else if (!ctrl_a_r[`BIT_TIMEOUT_OFF])
      timeout_cnt_r <= timeout_cnt_r + 17'h1;
  end

  // Guard time and inter-byte gap share one counter; direction change takes precedence.
  always @*
  begin
    cnt_load = 1'b0;
    cnt_value = 8'h00;
    if (rx_to_tx)
    begin
      cnt_load = 1'b1;
      cnt_value = guard_cycles(ctrl_a_r[2:0]);
    end
    else if (tx_byte_done && multibyte_load && ctrl_a_r[`BIT_GAP_EN])
    begin
      cnt_load = 1'b1;
      cnt_value = {6'h00, `GAP_BITS};
    end
  end

  link_counter u_wait
  (
    .clk(clk),
    .rst_n(rst_n),
    .load(cnt_load),
    .value(cnt_value),
    .busy(cnt_busy)
  );

  // Read mux; unmapped and reserved locations return zero.
  always @*
  begin
    rdata_nxt = 8'h00;
    case (reg_addr)
      `OFF_REV_STATUS: rdata_nxt = {`IMPL_REVISION, 4'h0};
      `OFF_ERR_STATUS: rdata_nxt = {5'h00, error_signature_r};
      `OFF_PHY_CTRL: rdata_nxt = ctrl_a_r;
      `OFF_PHY_CTRL_TWO: rdata_nxt = ctrl_b_r;
      `OFF_KEY_STATUS: rdata_nxt = {2'b00, user_row_key_flag_r, mem_program_key_flag_r, chip_erase_key_flag_r, 3'h0};
      `OFF_RESET_REQ: rdata_nxt = reset_req_r;
      `OFF_CLK_SEL: rdata_nxt = clk_sel_r;
      `OFF_SYS_CTRL: rdata_nxt = sys_ctrl_r;
      `OFF_SYS_STATUS: rdata_nxt = sys_status_r;
      `OFF_CRC_STATUS: rdata_nxt = {5'h00, crc_status_r};
      default: rdata_nxt = 8'h00;
    endcase
  end

  // Registered outputs; system reset derives from the request register only.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata <= 8'h00;
      tx_hold <= 1'b0;
      resp_sig_en <= 1'b1;
      nack_en <= 1'b1;
      parity_check_en <= 1'b1;
      contention_check_en <= 1'b1;
      phy_enable <= 1'b0;
      sys_clock_request <= 1'b0;
      system_reset <= 1'b0;
      user_row_done <= 1'b0;
      link_clock_divider <= `DIV_RESET;
    end
    else
    begin
      if (reg_rd)
        reg_rdata <= rdata_nxt;
      tx_hold <= cnt_busy || cnt_load;
      resp_sig_en <= resp_sig_req && !ctrl_a_r[`BIT_RESP_OFF];
      nack_en <= nack_req && !ctrl_a_r[`BIT_RESP_OFF] && !ctrl_b_r[`BIT_NACK_OFF];
      parity_check_en <= !ctrl_a_r[`BIT_PARITY_OFF];
      contention_check_en <= !ctrl_b_r[`BIT_CONT_OFF];
      phy_enable <= !link_dis;
      sys_clock_request <= sys_ctrl_r[0] && !link_dis;
      system_reset <= (reset_req_r == `RESET_HOLD);
      user_row_done <= sys_ctrl_r[`BIT_UROW_DONE];
      link_clock_divider <= clk_sel_r[1:0];
    end
  end
endmodule

// ===== verif/debug_link_checker.sv
// Concurrent checks on the ports of the debug link register block.
`timescale 1ns/1ps
module debug_link_checker (
  // Clock and reset.
  input wire clk,
  input wire nrst,
  // Register access.
  input wire reg_wr,
  input wire reg_rd,
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  // Events.
  input wire parity_err,
  input wire rx_to_tx,
  input wire resp_sig_req,
  input wire nack_req,
  // Watched outputs.
  input wire tx_hold,
  input wire resp_sig_en,
  input wire nack_en,
  input wire parity_check_en,
  input wire system_reset,
  input wire [1:0] link_clock_divider
);
  logic [2:0] age_r;
  logic [7:0] hold_r;
  // Outputs keep reset values for a few edges after release, so checks wait five edges.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      age_r <= 3'h0;
      hold_r <= 8'h00;
    end
    else
    begin
      if (age_r != 3'h5)
        age_r <= age_r + 3'h1;
      hold_r <= tx_hold ? hold_r + 8'h01 : 8'h00;
    end
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (age_r != 3'h5);
  sequence wr_at(logic [3:0] a);
    reg_wr && reg_addr == a;
  endsequence
  sequence wr_idle(logic [3:0] a);
    wr_at(a) ##1 !reg_wr;
  endsequence
  a_reset_hold: assert property (wr_at(4'h8) ##0 reg_wdata == 8'h59 |-> ##2 system_reset)
    else $error("system reset not raised");
  a_reset_free: assert property (wr_at(4'h8) ##0 reg_wdata == 8'h00 |-> ##2 !system_reset)
    else $error("system reset not released");
  a_parity_cfg: assert property (wr_idle(4'h2) |=> parity_check_en == !$past(reg_wdata[5], 2))
    else $error("parity check enable wrong");
  a_div_sel: assert property (wr_idle(4'h9) |=> link_clock_divider == $past(reg_wdata[1:0], 2))
    else $error("clock divider wrong");
  a_parity_sig: assert property (parity_err && parity_check_en ##[1:2] reg_rd && reg_addr == 4'h1
    |=> reg_rdata == 8'h01)
    else $error("parity signature wrong");
  a_guard_start: assert property (rx_to_tx |=> tx_hold)
    else $error("guard wait not started");
  a_guard_max: assert property (tx_hold |-> hold_r < 8'h80)
    else $error("guard wait too long");
  a_resp_src: assert property (resp_sig_en |-> $past(resp_sig_req))
    else $error("response signature without request");
  a_nack_src: assert property (nack_en |-> $past(nack_req))
    else $error("negative acknowledge without request");
endmodule
bind debug_link_control_regs debug_link_checker chk_u (
  .clk(clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .parity_err(parity_err), .rx_to_tx(rx_to_tx), .resp_sig_req(resp_sig_req),
  .nack_req(nack_req), .tx_hold(tx_hold), .resp_sig_en(resp_sig_en), .nack_en(nack_en),
  .parity_check_en(parity_check_en), .system_reset(system_reset), .link_clock_divider(link_clock_divider));

// ===== verif/link_host_model.sv
// Debugger-side model that reaches the registers only through link instruction strobes.
`timescale 1ns/1ps
module link_host_model (
  // Clock.
  input wire clk,
  // Register access.
  output logic reg_wr,
  output logic reg_rd,
  output logic [3:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire [7:0] reg_rdata
);
  // Idle strobes at time zero.
  initial
  begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
  end
  // One write; data is inverted afterwards so no check leans on a stale value.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
  // One read; the registered answer is settled at the edge that takes the strobe.
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge clk);
    #1;
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask
endmodule

// ===== verif/tb.sv
// Self-checking bench for the debug link register block.
`timescale 1ns/1ps
`include "debug_link_defs.vh"
module tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [15:0] ev = 16'h0000;
  logic [7:0] d;
  int errors = 0;
  int n_checks = 0;
  int cyc = 0;
  int n;
  wire reg_wr;
  wire reg_rd;
  wire [3:0] reg_addr;
  wire [7:0] reg_wdata;
  wire [7:0] reg_rdata;
  wire tx_hold;
  wire resp_sig_en;
  wire nack_en;
  wire parity_check_en;
  wire contention_check_en;
  wire phy_enable;
  wire sys_clock_request;
  wire user_row_done;
  wire system_reset;
  wire [1:0] link_clock_divider;
  link_host_model host_u (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  debug_link_control_regs dut_u (.clk(clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .parity_err(ev[0]), .frame_err(ev[1]),
    .clock_err(ev[2]), .bus_err(ev[3]), .contention_seen(ev[4]), .acc_request(ev[5]), .acc_response(ev[6]),
    .rx_to_tx(ev[7]), .tx_byte_done(ev[8]), .multibyte_load(ev[9]), .resp_sig_req(ev[10]), .nack_req(ev[11]),
    .user_row_key_dec(ev[12]), .mem_program_key_dec(ev[13]), .chip_erase_key_dec(ev[14]),
    .program_start_pin(ev[15]), .sys_status_pin(8'h5a), .crc_status_pin(3'h4), .tx_hold(tx_hold),
    .resp_sig_en(resp_sig_en), .nack_en(nack_en), .parity_check_en(parity_check_en),
    .contention_check_en(contention_check_en), .phy_enable(phy_enable), .sys_clock_request(sys_clock_request),
    .system_reset(system_reset), .user_row_done(user_row_done), .link_clock_divider(link_clock_divider));
  always #5 clk = ~clk;
  // Cuts a hang short; the longest wait is the access time-out.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      errors++;
      end_of_test();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
    host_u.rd(a, d);
    check(d, exp);
  endtask
  task automatic pulse(input int i);
    @(posedge clk);
    #1;
    ev[i] = 1'b1;
    @(posedge clk);
    #1;
    ev[i] = 1'b0;
  endtask
  // Counts the cycles of transmit hold that follow an event.
  task automatic hold_len(input int i);
    pulse(i);
    n = 0;
    while (tx_hold === 1'b1 && n < 300)
    begin
      n++;
      @(posedge clk);
      #1;
    end
  endtask
  task automatic t_regs();
    rdchk(4'h0, {`IMPL_REVISION, 4'h0});
    rdchk(4'hc, 8'h04);
    rdchk(4'hb, 8'h5a);
    rdchk(4'h9, `CLK_SEL_RESET);
    host_u.wr(4'h0, 8'hff);
    rdchk(4'h0, {`IMPL_REVISION, 4'h0});
    host_u.wr(4'h2, 8'hff);
    rdchk(4'h2, `CTRL_A_MASK);
    host_u.wr(4'h5, 8'hff);
    rdchk(4'h5, 8'h00);
    for (int k = 0; k < 4; k++)
    begin
      host_u.wr(4'h9, 8'(k));
      @(posedge clk);
      #1;
      check(link_clock_divider, 8'(k));
    end
    $display("registers done");
  endtask
  task automatic t_errors();
    logic [2:0] code [5] = '{`SIG_PARITY, `SIG_FRAME, `SIG_CLOCK, `SIG_BUS, `SIG_CONTENTION};
    host_u.wr(4'h2, 8'h00);
    for (int k = 0; k < 5; k++)
    begin
      pulse(k);
      rdchk(4'h1, {5'h0, code[k]});
      rdchk(4'h1, 8'h00);
    end
    host_u.wr(4'h2, 8'h20);
    host_u.wr(4'h3, 8'h08);
    pulse(0);
    pulse(4);
    rdchk(4'h1, 8'h00);
    check({parity_check_en, contention_check_en}, 8'h00);
    host_u.wr(4'h2, 8'h00);
    ev[5] = 1'b1;
    repeat (65530) @(posedge clk);
    rdchk(4'h1, 8'h00);
    repeat (8) @(posedge clk);
    #1;
    ev[5] = 1'b0;
    pulse(6);
    rdchk(4'h1, {5'h0, `SIG_TIMEOUT});
    $display("errors done");
  endtask
  task automatic t_guard();
    for (int g = 0; g < 8; g++)
    begin
      host_u.wr(4'h2, 8'(g));
      hold_len(7);
      check(8'(n), g == 7 ? 8'h80 : 8'h80 >> g);
    end
    ev[9] = 1'b1;
    host_u.wr(4'h2, 8'h80);
    hold_len(8);
    check(8'(n), {6'h0, `GAP_BITS});
    host_u.wr(4'h2, 8'h00);
    hold_len(8);
    check(8'(n), 8'h00);
    ev[9] = 1'b0;
    $display("guard done");
  endtask
  task automatic t_sigs();
    for (int k = 0; k < 3; k++)
    begin
      host_u.wr(4'h2, k == 1 ? 8'h08 : 8'h00);
      host_u.wr(4'h3, k == 2 ? 8'h10 : 8'h00);
      pulse(10);
      check(resp_sig_en, k != 1);
      pulse(11);
      check(nack_en, k == 0);
    end
    $display("signatures done");
  endtask
  task automatic t_keys();
    pulse(12);
    pulse(13);
    pulse(14);
    rdchk(4'h7, 8'h38);
    ev[15] = 1'b1;
    repeat (6) @(posedge clk);
    rdchk(4'h7, 8'h28);
    host_u.wr(4'h8, `RESET_HOLD);
    @(posedge clk);
    #1;
    check(system_reset, 1'b1);
    rdchk(4'h7, 8'h20);
    rdchk(4'h8, `RESET_HOLD);
    host_u.wr(4'h8, `RESET_RUN);
    @(posedge clk);
    #1;
    check(system_reset, 1'b0);
    host_u.wr(4'ha, 8'h03);
    @(posedge clk);
    #1;
    check({phy_enable, sys_clock_request, user_row_done}, 8'h07);
    host_u.wr(4'h7, 8'h20);
    rdchk(4'h7, 8'h00);
    host_u.wr(4'ha, 8'h03);
    rdchk(4'ha, 8'h01);
    host_u.wr(4'h9, 8'h01);
    host_u.wr(4'h2, 8'h25);
    host_u.wr(4'h3, 8'h04);
    @(posedge clk);
    #1;
    check({phy_enable, sys_clock_request}, 8'h00);
    rdchk(4'h2, 8'h00);
    rdchk(4'h9, `CLK_SEL_RESET);
    check({phy_enable, sys_clock_request}, 8'h02);
    $display("keys done");
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    #1;
    nrst = 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    t_errors();
    t_guard();
    t_sigs();
    t_keys();
    end_of_test();
  end
endmodule
